// File: logic/pmsmr_pkg.sv
// pmsmr_pkg: constants shared by both ends of the nibble / reduced transceiver-to-controller link
// assumes: every user of these names writes pmsmr_pkg::name, both ends run on a 125 MHz REF_CLK
// Operation
// - nibble mode moves 4-bit words both ways
// - carrier sense while receiving, or while transmitting in nibble mode
// - collision: both active in half duplex
// - slave mode: both share one reference clock
// - master mode: transceiver drives link clock out
// - master strap enables clock on third pin
// - reduced mode moves two bits per clock
// - both ends sample on reference clock edges
// - 10 Mbps: one transfer per ten clocks
// - reduced mode: separate valid and error outputs
// - elastic buffer, threshold 4/8/12/16 bits in reduced mode, fixed at 4 bits in nibble mode
// - software picks threshold from packet size
// - 3-bit clock select per clock pin
// - interface clock follows selected interface rate
// - pass-through option drives the reference clock divided by two
// - free-running and recovered clock options
// - internal clocking all from local reference
package pmsmr_pkg;
  // =====================================================================
  // clocking
  localparam int REF_CLK_MHZ    = 125;
  localparam int NIBBLE_CLK_MHZ = 25;
  localparam int REDUCED_CLK_MHZ = 50;
  localparam int NIBBLE_PERIOD  = (REF_CLK_MHZ + NIBBLE_CLK_MHZ - 1) / NIBBLE_CLK_MHZ;
  localparam int REDUCED_PERIOD = (REF_CLK_MHZ + REDUCED_CLK_MHZ - 1) / REDUCED_CLK_MHZ;
  localparam logic [3:0] SLOW_DECIMATE = 4'hA;
  localparam logic [1:0] STRAP_SETTLE  = 2'h3;
  // =====================================================================
  // registers
  localparam logic [15:0] ADDR_CTRL_ONE   = 16'h0462;
  localparam logic [15:0] ADDR_CTRL_TWO   = 16'h0463;
  localparam logic [15:0] CTRL_RESET      = 16'h0000;
  localparam int          SEL_THIRD_LSB   = 12;
  localparam int          SEL_FIRST_LSB   = 4;
  localparam int          SEL_SECOND_LSB  = 4;
  localparam int          SEL_WIDTH       = 3;
  localparam logic [2:0]  CLKSEL_OFF      = 3'h0;
  localparam logic [2:0]  CLKSEL_HOST_IF  = 3'h1;
  localparam logic [2:0]  CLKSEL_REF_PASS = 3'h2;
  localparam logic [2:0]  CLKSEL_FREE     = 3'h3;
  localparam logic [2:0]  CLKSEL_RECOV    = 3'h4;
  // =====================================================================
  // elastic buffer
  localparam int          ELASTIC_DEPTH   = 32;
  localparam logic [5:0]  ELASTIC_ROOM    = 6'h1C;
  localparam logic [5:0]  THRESH_STEP     = 6'h04;
endpackage

// File: logic/pmsmr_link_if.sv
// pmsmr_link_if: the wires between transceiver end and controller end
// assumes: the transceiver end makes link_clk; crs carries combined carrier/valid in reduced mode
`timescale 1ns/100ps
interface pmsmr_link_if;
  logic       link_clk;
  logic       tx_en;
  logic [3:0] txd;
  logic [3:0] rxd;
  logic       crs;
  logic       col;
  logic       rx_dv;
  logic       rx_er;
  modport phy (output link_clk, output rxd, output crs, output col, output rx_dv, output rx_er,
               input tx_en, input txd);
  modport mac (input link_clk, input rxd, input crs, input col, input rx_dv, input rx_er,
               output tx_en, output txd);
endinterface

// File: logic/pmsmr_phy_end.sv
// pmsmr_phy_end: transceiver end, makes the link clock, elastic receive buffer, clock pin muxes
// assumes: line-side ports and configuration levels are on REF_CLK; link tx pins and strap are asynchronous
`timescale 1ns/100ps
module pmsmr_phy_end (
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  pmsmr_link_if.phy        LINK,
  input  wire logic        MODE_REDUCED,
  input  wire logic        SPEED_10,
  input  wire logic        HALF_DUPLEX,
  input  wire logic [2:0]  ELASTIC_START_THRESHOLD,
  input  wire logic        STRAP_MASTER,
  input  wire logic        LINE_LINK_UP,
  input  wire logic        LINE_RX_ACTIVE,
  input  wire logic        LINE_RX_VALID,
  input  wire logic [3:0]  LINE_RX_DATA,
  output logic             LINE_RX_READY,
  output logic             LINE_TX_VALID,
  output logic [3:0]       LINE_TX_DATA,
  output logic             LINE_TX_ACTIVE,
  input  wire logic        REG_WE,
  input  wire logic [15:0] REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  output logic [15:0]      REG_RDATA,
  output logic             CLK_PIN_FIRST,
  output logic             CLK_PIN_SECOND,
  output logic             CLK_PIN_THIRD,
  output logic             STRAP_IS_MASTER
);
  // =====================================================================
  // state
  typedef struct packed {
    logic        strap_m;
    logic        strap_s;
    logic [1:0]  strap_cnt;
    logic        master;
    logic [4:0]  tx_m;
    logic [4:0]  tx_s;
    logic [15:0] ctrl_one;
    logic [15:0] ctrl_two;
    logic [15:0] rdata;
    logic [2:0]  ph;
    logic        link_clk;
    logic [3:0]  rdec;
    logic [3:0]  tdec;
    logic [31:0] eb;
    logic [4:0]  wp;
    logic [4:0]  rp;
    logic [5:0]  cnt;
    logic        rx_run;
    logic        rx_ready;
    logic [3:0]  rxd;
    logic        rx_dv;
    logic        rx_er;
    logic        crs;
    logic        col;
    logic        tx_act;
    logic        tx_half;
    logic [1:0]  tx_lo;
    logic        ltx_valid;
    logic [3:0]  ltx_data;
    logic        tog;
    logic [2:0]  pins;
  } pmsmr_phy_state_s;

  pmsmr_phy_state_s s;
  pmsmr_phy_state_s next_s;

  // =====================================================================
  // next state
  always_comb
  begin
    logic [2:0] per;
    logic       tick;
    logic       rx_beat;
    logic       tx_beat;
    logic [5:0] thr;
    logic [5:0] step;
    logic       push;
    logic       pop;
    logic [3:0] rbits;
    logic [2:0] sel;
    logic [4:0] idx;
    per     = MODE_REDUCED ? 3'(pmsmr_pkg::REDUCED_PERIOD) : 3'(pmsmr_pkg::NIBBLE_PERIOD);
    tick    = 1'b0;
    rx_beat = 1'b0;
    tx_beat = 1'b0;
    thr     = 6'h00;
    step    = 6'h00;
    push    = 1'b0;
    pop     = 1'b0;
    rbits   = 4'h0;
    sel     = 3'h0;
    idx     = 5'h00;
    next_s  = s;

    // strap caught a few edges after reset release, once
    next_s.strap_m = STRAP_MASTER;
    next_s.strap_s = s.strap_m;
    if (s.strap_cnt != pmsmr_pkg::STRAP_SETTLE)
    begin
      next_s.strap_cnt = s.strap_cnt + 2'h1;
      if (s.strap_cnt == pmsmr_pkg::STRAP_SETTLE - 2'h1)
        next_s.master = s.strap_s;
    end
    next_s.tx_m = {LINK.tx_en, LINK.txd};
    next_s.tx_s = s.tx_m;

    // register port, unmapped reads zero
    if (REG_WE && REG_ADDR == pmsmr_pkg::ADDR_CTRL_ONE)
      next_s.ctrl_one = REG_WDATA;
    if (REG_WE && REG_ADDR == pmsmr_pkg::ADDR_CTRL_TWO)
      next_s.ctrl_two = REG_WDATA;
    case (REG_ADDR)
      pmsmr_pkg::ADDR_CTRL_ONE: next_s.rdata = s.ctrl_one;
      pmsmr_pkg::ADDR_CTRL_TWO: next_s.rdata = s.ctrl_two;
      default:                  next_s.rdata = 16'h0000;
    endcase

    // link clock divided from the local reference, rate follows the mode
    tick = (s.ph >= per - 3'h1);
    next_s.ph       = tick ? 3'h0 : s.ph + 3'h1;
    // high phase only extends a rise, so no short pulse follows reset
    next_s.link_clk = tick ? 1'b1 : (s.link_clk && ((s.ph + 3'h1) < (per >> 1)));
    if (tick)
    begin
      next_s.rdec = (s.rdec == pmsmr_pkg::SLOW_DECIMATE - 4'h1) ? 4'h0 : s.rdec + 4'h1;
      next_s.tdec = (s.tdec == pmsmr_pkg::SLOW_DECIMATE - 4'h1) ? 4'h0 : s.tdec + 4'h1;
    end
    rx_beat = tick && (!SPEED_10 || s.rdec == 4'h0);
    tx_beat = tick && (!SPEED_10 || s.tdec == 4'h0 || (s.tx_s[4] && !s.tx_act));
    if (tick && s.tx_s[4] && !s.tx_act)
      next_s.tdec = 4'h1;

    // elastic buffer, threshold in 4-bit steps
    thr  = (ELASTIC_START_THRESHOLD == 3'h0 || !MODE_REDUCED) ? pmsmr_pkg::THRESH_STEP
         : (ELASTIC_START_THRESHOLD > 3'h4) ? 6'(4 * 4) : 6'(4 * ELASTIC_START_THRESHOLD);
    step = MODE_REDUCED ? 6'h02 : 6'h04;
    push = LINE_RX_VALID && s.rx_ready;
    for (int i = 0; i < 4; i++)
    begin
      idx = s.wp + 5'(i);
      if (push)
        next_s.eb[idx] = LINE_RX_DATA[i];
      idx = s.rp + 5'(i);
      rbits[i] = s.eb[idx];
    end
    if (push)
      next_s.wp = s.wp + 5'h04;
    if (rx_beat)
    begin
      if (s.rx_run || s.cnt >= thr)
      begin
        next_s.rx_run = 1'b1;
        if (s.cnt >= step)
        begin
          pop          = 1'b1;
          next_s.rxd   = MODE_REDUCED ? {2'b00, rbits[1:0]} : rbits;
          next_s.rx_dv = 1'b1;
          next_s.rx_er = 1'b0;
          next_s.rp    = s.rp + 5'(step);
        end
        else if (LINE_RX_ACTIVE)
        begin
          next_s.rx_dv = 1'b1;
          next_s.rx_er = 1'b1;
          next_s.rxd   = 4'h0;
        end
        else
        begin
          next_s.rx_run = 1'b0;
          next_s.rx_dv  = 1'b0;
          next_s.rx_er  = 1'b0;
          next_s.rxd    = 4'h0;
        end
      end
      else
      begin
        next_s.rx_dv = 1'b0;
        next_s.rx_er = 1'b0;
        next_s.rxd   = 4'h0;
      end
    end
    next_s.cnt      = s.cnt + (push ? 6'h04 : 6'h00) - (pop ? step : 6'h00);
    next_s.rx_ready = (next_s.cnt <= pmsmr_pkg::ELASTIC_ROOM);

    // transmit sampling, dibits paired low first
    next_s.ltx_valid = 1'b0;
    if (tx_beat)
    begin
      if (s.tx_s[4])
      begin
        next_s.tx_act = 1'b1;
        if (!MODE_REDUCED)
        begin
          next_s.ltx_valid = 1'b1;
          next_s.ltx_data  = s.tx_s[3:0];
        end
        else if (!s.tx_half)
        begin
          next_s.tx_lo   = s.tx_s[1:0];
          next_s.tx_half = 1'b1;
        end
        else
        begin
          next_s.ltx_valid = 1'b1;
          next_s.ltx_data  = {s.tx_s[1:0], s.tx_lo};
          next_s.tx_half   = 1'b0;
        end
      end
      else
      begin
        next_s.tx_act  = 1'b0;
        next_s.tx_half = 1'b0;
      end
    end

    // line status toward the controller
    if (MODE_REDUCED)
      next_s.crs = LINE_RX_ACTIVE || next_s.rx_run;
    else
      next_s.crs = LINE_RX_ACTIVE || next_s.rx_run || next_s.tx_act;
    next_s.col = HALF_DUPLEX && (LINE_RX_ACTIVE || next_s.rx_run) && next_s.tx_act;

    // clock pin muxes
    next_s.tog = ~s.tog;
    for (int p = 0; p < 3; p++)
    begin
      case (p)
        0:       sel = s.ctrl_one[pmsmr_pkg::SEL_FIRST_LSB +: pmsmr_pkg::SEL_WIDTH];
        1:       sel = s.ctrl_two[pmsmr_pkg::SEL_SECOND_LSB +: pmsmr_pkg::SEL_WIDTH];
        default: sel = s.ctrl_one[pmsmr_pkg::SEL_THIRD_LSB +: pmsmr_pkg::SEL_WIDTH];
      endcase
      if (p == 2 && sel == pmsmr_pkg::CLKSEL_OFF && s.master)
        sel = pmsmr_pkg::CLKSEL_HOST_IF;
      case (sel)
        pmsmr_pkg::CLKSEL_HOST_IF:  next_s.pins[p] = next_s.link_clk;
        pmsmr_pkg::CLKSEL_REF_PASS: next_s.pins[p] = next_s.tog;
        pmsmr_pkg::CLKSEL_FREE:     next_s.pins[p] = next_s.tog;
        pmsmr_pkg::CLKSEL_RECOV:    next_s.pins[p] = next_s.tog && LINE_LINK_UP;
        default:                    next_s.pins[p] = 1'b0;
      endcase
    end
  end

  // =====================================================================
  // registers
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      s          <= '0;
      s.ctrl_one <= pmsmr_pkg::CTRL_RESET;
      s.ctrl_two <= pmsmr_pkg::CTRL_RESET;
    end
    else
      s <= next_s;
  end

  // =====================================================================
  // outputs
  assign LINK.link_clk   = s.link_clk;
  assign LINK.rxd        = s.rxd;
  assign LINK.crs        = s.crs;
  assign LINK.col        = s.col;
  assign LINK.rx_dv      = s.rx_dv;
  assign LINK.rx_er      = s.rx_er;
  assign LINE_RX_READY   = s.rx_ready;
  assign LINE_TX_VALID   = s.ltx_valid;
  assign LINE_TX_DATA    = s.ltx_data;
  assign LINE_TX_ACTIVE  = s.tx_act;
  assign REG_RDATA       = s.rdata;
  assign CLK_PIN_FIRST   = s.pins[0];
  assign CLK_PIN_SECOND  = s.pins[1];
  assign CLK_PIN_THIRD   = s.pins[2];
  assign STRAP_IS_MASTER = s.master;
endmodule // pmsmr_phy_end

// File: logic/pmsmr_mac_end.sv
// pmsmr_mac_end: controller end, samples the link clock, two-entry transmit buffer, receive assembly
// assumes: user ports on REF_CLK; every link input is asynchronous and double-synchronised here
`timescale 1ns/100ps
module pmsmr_mac_end (
  input  wire logic       REF_CLK,
  input  wire logic       SYS_RST,
  pmsmr_link_if.mac       LINK,
  input  wire logic       MODE_REDUCED,
  input  wire logic       SPEED_10,
  input  wire logic       TX_VALID,
  input  wire logic [3:0] TX_DATA,
  input  wire logic       TX_LAST,
  output logic            TX_READY,
  output logic            RX_VALID,
  output logic [3:0]      RX_DATA,
  output logic            RX_ERR,
  output logic            RX_END,
  output logic            CRS,
  output logic            COL
);
  // =====================================================================
  // state
  typedef struct packed {
    logic [8:0]      in_m;
    logic [8:0]      in_s;
    logic            clk_prev;
    logic [3:0]      rdec;
    logic [3:0]      tdec;
    logic            rx_on;
    logic            rx_half;
    logic [1:0]      rx_lo;
    logic            rx_valid;
    logic [3:0]      rx_data;
    logic            rx_err;
    logic            rx_end;
    logic            crs;
    logic            col;
    logic [1:0][4:0] buf_q;
    logic            wp;
    logic            rp;
    logic [1:0]      cnt;
    logic            tx_ready;
    logic            tx_en;
    logic [3:0]      txd;
    logic            tx_half;
    logic            fin;
  } pmsmr_mac_state_s;

  pmsmr_mac_state_s s;
  pmsmr_mac_state_s next_s;

  // =====================================================================
  // next state
  always_comb
  begin
    logic       rise;
    logic       rx_beat;
    logic       tx_beat;
    logic       dv;
    logic [3:0] d;
    logic       push;
    logic       pop;
    logic [4:0] head;
    rise    = 1'b0;
    rx_beat = 1'b0;
    tx_beat = 1'b0;
    push    = 1'b0;
    pop     = 1'b0;
    next_s  = s;
    next_s.in_m = {LINK.link_clk, LINK.crs, LINK.col, LINK.rx_dv, LINK.rx_er, LINK.rxd};
    next_s.in_s = s.in_m;
    dv   = s.in_s[5];
    d    = s.in_s[3:0];
    head = s.buf_q[s.rp];

    // rising edge of the sampled link clock is the transfer point
    next_s.clk_prev = s.in_s[8];
    rise = s.in_s[8] && !s.clk_prev;
    if (rise)
    begin
      next_s.rdec = (s.rdec == pmsmr_pkg::SLOW_DECIMATE - 4'h1) ? 4'h0 : s.rdec + 4'h1;
      next_s.tdec = (s.tdec == pmsmr_pkg::SLOW_DECIMATE - 4'h1) ? 4'h0 : s.tdec + 4'h1;
      next_s.crs  = s.in_s[7];
      next_s.col  = s.in_s[6];
    end
    rx_beat = rise && (!SPEED_10 || s.rdec == 4'h0 || (dv && !s.rx_on));
    tx_beat = rise && (!SPEED_10 || s.tdec == 4'h0);
    if (rise && dv && !s.rx_on)
      next_s.rdec = 4'h1;

    // receive assembly, dibits low first in reduced mode
    next_s.rx_valid = 1'b0;
    next_s.rx_end   = 1'b0;
    if (rx_beat)
    begin
      if (dv)
      begin
        next_s.rx_on = 1'b1;
        if (!MODE_REDUCED)
        begin
          next_s.rx_valid = 1'b1;
          next_s.rx_data  = d;
          next_s.rx_err   = s.in_s[4];
        end
        else if (!s.rx_half)
        begin
          next_s.rx_lo   = d[1:0];
          next_s.rx_half = 1'b1;
          next_s.rx_err  = s.in_s[4];
        end
        else
        begin
          next_s.rx_valid = 1'b1;
          next_s.rx_data  = {d[1:0], s.rx_lo};
          next_s.rx_err   = s.rx_err || s.in_s[4];
          next_s.rx_half  = 1'b0;
        end
      end
      else if (s.rx_on)
      begin
        next_s.rx_on   = 1'b0;
        next_s.rx_half = 1'b0;
        next_s.rx_end  = 1'b1;
      end
    end

    // transmit drain from the two-entry buffer
    if (tx_beat)
    begin
      if (s.tx_half)
      begin
        next_s.txd     = {2'b00, head[3:2]};
        next_s.tx_half = 1'b0;
        next_s.fin     = head[4];
        pop            = 1'b1;
      end
      else if (s.cnt != 2'h0 && !s.fin)
      begin
        next_s.tx_en = 1'b1;
        if (MODE_REDUCED)
        begin
          next_s.txd     = {2'b00, head[1:0]};
          next_s.tx_half = 1'b1;
        end
        else
        begin
          next_s.txd = head[3:0];
          next_s.fin = head[4];
          pop        = 1'b1;
        end
      end
      else
      begin
        next_s.tx_en = 1'b0;
        next_s.txd   = 4'h0;
        next_s.fin   = 1'b0;
      end
    end
    if (pop)
      next_s.rp = ~s.rp;
    push = TX_VALID && s.tx_ready;
    if (push)
    begin
      next_s.buf_q[s.wp] = {TX_LAST, TX_DATA};
      next_s.wp          = ~s.wp;
    end
    next_s.cnt      = s.cnt + (push ? 2'h1 : 2'h0) - (pop ? 2'h1 : 2'h0);
    next_s.tx_ready = (next_s.cnt != 2'h2);
  end

  // =====================================================================
  // registers
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      s <= '0;
    else
      s <= next_s;
  end

  // =====================================================================
  // outputs
  assign LINK.tx_en = s.tx_en;
  assign LINK.txd   = s.txd;
  assign TX_READY   = s.tx_ready;
  assign RX_VALID   = s.rx_valid;
  assign RX_DATA    = s.rx_data;
  assign RX_ERR     = s.rx_err;
  assign RX_END     = s.rx_end;
  assign CRS        = s.crs;
  assign COL        = s.col;
endmodule // pmsmr_mac_end

// File: tb/pmsmr_link_chk.sv
// pmsmr_link_chk: timing checks on the wires between the two ends
// assumes: mode levels change only while SYS_RST is high, one REF_CLK domain
`timescale 1ns/100ps
module pmsmr_link_chk (
  input wire logic       REF_CLK,
  input wire logic       SYS_RST,
  input wire logic       MODE_REDUCED,
  input wire logic       SPEED_10,
  input wire logic       HALF_DUPLEX,
  input wire logic       link_clk,
  input wire logic       tx_en,
  input wire logic [3:0] txd,
  input wire logic [3:0] rxd,
  input wire logic       crs,
  input wire logic       col,
  input wire logic       rx_dv,
  input wire logic       rx_er
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);
  // ==========================================================================
  // link clock shape
  a_nibble_clk_rate: assert property (!MODE_REDUCED && $rose(link_clk) |->
    link_clk[*2] ##1 !link_clk[*3] ##1 link_clk) else $error("nibble link clock period wrong");
  a_reduced_clk_rate: assert property (MODE_REDUCED && $rose(link_clk) |->
    link_clk ##1 !link_clk[*2] ##1 link_clk) else $error("reduced link clock period wrong");
  // ==========================================================================
  // data timing
  a_rx_on_edge: assert property ($changed(rxd) || $changed(rx_dv) |-> $rose(link_clk))
    else $error("receive data moved off a link clock rise");
  a_reduced_upper_zero: assert property (MODE_REDUCED |-> rxd[3:2] == 2'h0 && txd[3:2] == 2'h0)
    else $error("upper data bits used in reduced mode");
  a_tx_beat_hold: assert property (!MODE_REDUCED && $changed(txd) |=> $stable(txd)[*4])
    else $error("transmit nibble held less than a beat");
  a_slow_rx_hold: assert property (SPEED_10 && $changed(rxd) |=> $stable(rxd)[*8])
    else $error("slow receive data changed too soon");
  // ==========================================================================
  // status
  a_crs_on_tx: assert property ((!MODE_REDUCED && !SPEED_10 && tx_en)[*8] ##1 tx_en |-> crs)
    else $error("carrier missing while transmitting");
  a_col_half_only: assert property (col |-> HALF_DUPLEX)
    else $error("collision in full duplex");
  a_err_flags: assert property (rx_er |-> rx_dv && rxd == 4'h0)
    else $error("receive error without valid");
endmodule // pmsmr_link_chk

// File: tb/tb_phy_mac_side_mii_rmii.sv
// tb_phy_mac_side_mii_rmii: both ends joined by the link, traffic both ways, clock pins
// assumes: 125 MHz REF_CLK, config levels changed only under reset
`timescale 1ns/100ps
module tb_phy_mac_side_mii_rmii;
  logic        ref_clk, sys_rst, mode_reduced, speed_10, half_duplex, strap_master, link_up;
  logic        rx_active, rx_valid, rx_ready, ltx_valid, reg_we, strap_is_master, ltx_act;
  logic [3:0]  rx_data, ltx_data, tx_data, m_data;
  logic [2:0]  thresh;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic        pin1, pin2, pin3, tx_valid, tx_last, tx_ready, m_valid, m_err, m_end, m_crs, m_col;
  logic [3:0]  txq[$];
  logic [3:0]  rxq[$];
  bit          err_seen, col_seen, crs_seen;
  int          end_seen, fail_count, comparisons;
  wire  [2:0]  pins = {pin3, pin2, pin1};
  pmsmr_link_if link_if ();
  pmsmr_phy_end i_pmsmr_phy_end (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .LINK(link_if),
    .MODE_REDUCED(mode_reduced), .SPEED_10(speed_10), .HALF_DUPLEX(half_duplex),
    .ELASTIC_START_THRESHOLD(thresh), .STRAP_MASTER(strap_master), .LINE_LINK_UP(link_up),
    .LINE_RX_ACTIVE(rx_active), .LINE_RX_VALID(rx_valid), .LINE_RX_DATA(rx_data),
    .LINE_RX_READY(rx_ready), .LINE_TX_VALID(ltx_valid), .LINE_TX_DATA(ltx_data),
    .LINE_TX_ACTIVE(ltx_act), .REG_WE(reg_we), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata), .CLK_PIN_FIRST(pin1), .CLK_PIN_SECOND(pin2), .CLK_PIN_THIRD(pin3),
    .STRAP_IS_MASTER(strap_is_master));
  pmsmr_mac_end i_pmsmr_mac_end (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .LINK(link_if),
    .MODE_REDUCED(mode_reduced), .SPEED_10(speed_10), .TX_VALID(tx_valid), .TX_DATA(tx_data),
    .TX_LAST(tx_last), .TX_READY(tx_ready), .RX_VALID(m_valid), .RX_DATA(m_data),
    .RX_ERR(m_err), .RX_END(m_end), .CRS(m_crs), .COL(m_col));
  pmsmr_link_chk i_chk (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .MODE_REDUCED(mode_reduced),
    .SPEED_10(speed_10), .HALF_DUPLEX(half_duplex), .link_clk(link_if.link_clk),
    .tx_en(link_if.tx_en), .txd(link_if.txd), .rxd(link_if.rxd), .crs(link_if.crs),
    .col(link_if.col), .rx_dv(link_if.rx_dv), .rx_er(link_if.rx_er));
  // ==========================================================================
  // clock, monitors, watchdog
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    if (ltx_valid === 1'b1) txq.push_back(ltx_data);
    if (ltx_valid === 1'b1) chk(16'(ltx_act), 16'h0001);
    if (m_valid === 1'b1) rxq.push_back(m_data);
    if (m_valid === 1'b1 && m_err === 1'b1) err_seen = 1'b1;
    if (m_end === 1'b1) end_seen++;
    if (m_col === 1'b1) col_seen = 1'b1;
    if (m_crs === 1'b1) crs_seen = 1'b1;
  end
  // the tests need a few thousand cycles; this allows 100k
  initial
  begin
    #800000;
    fail_count++;
    stop_test();
  end
  // ==========================================================================
  // tasks
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic restart(input logic red, input logic slow, input logic half, input logic [2:0] th,
                         input logic strap);
    @(negedge ref_clk);
    sys_rst = 1'b1;
    mode_reduced = red;
    speed_10 = slow;
    half_duplex = half;
    thresh = th;
    strap_master = strap;
    repeat (16) @(negedge ref_clk);
    sys_rst = 1'b0;
    txq.delete();
    rxq.delete();
    {err_seen, col_seen, crs_seen, end_seen} = '0;
  endtask
  task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    reg_we = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_we = 1'b0;
  endtask
  task automatic reg_rd(input logic [15:0] a, input logic [15:0] exp);
    @(negedge ref_clk);
    reg_addr = a;
    repeat (2) @(negedge ref_clk);
    chk(reg_rdata, exp);
  endtask
  task automatic count_rises(input int idx, input int exp);
    int  n;
    logic p;
    n = 0;
    @(posedge ref_clk);
    #1;
    p = pins[idx];
    repeat (60)
    begin
      @(posedge ref_clk);
      #1;
      if (pins[idx] === 1'b1 && p === 1'b0) n++;
      p = pins[idx];
    end
    chk(n[15:0], exp[15:0]);
  endtask
  task automatic tx_push(input logic [3:0] d, input logic l);
    int t;
    @(negedge ref_clk);
    tx_valid = 1'b1;
    tx_data = d;
    tx_last = l;
    t = 0;
    do @(posedge ref_clk); while (tx_ready !== 1'b1 && ++t < 2000);
    chk(16'(t >= 2000), 16'h0000);
  endtask
  task automatic line_push(input logic [3:0] d);
    int t;
    @(negedge ref_clk);
    rx_valid = 1'b1;
    rx_data = d;
    t = 0;
    do @(posedge ref_clk); while (rx_ready !== 1'b1 && ++t < 2000);
    chk(16'(t >= 2000), 16'h0000);
  endtask
  // one frame each way at once, both compared nibble by nibble
  task automatic traffic(input int n);
    logic [3:0] exp[$];
    int         t;
    for (int i = 0; i < n; i++) exp.push_back(4'(i * 5 + 3));
    fork
      begin
        foreach (exp[i]) tx_push(exp[i], i == n - 1);
        @(negedge ref_clk);
        tx_valid = 1'b0;
        tx_last = 1'b0;
      end
      begin
        rx_active = 1'b1;
        foreach (exp[i]) line_push(~exp[i]);
        @(negedge ref_clk);
        rx_valid = 1'b0;
        rx_active = 1'b0;
      end
    join
    t = 0;
    while ((txq.size() < n || end_seen == 0) && t++ < 3000) @(negedge ref_clk);
    chk(16'(t > 3000), 16'h0000);
    chk(16'(txq.size()), 16'(n));
    chk(16'(rxq.size()), 16'(n));
    foreach (exp[i])
    begin
      chk(16'(txq[i]), 16'(exp[i]));
      chk(16'(rxq[i]), 16'(4'(~exp[i])));
    end
    txq.delete();
    rxq.delete();
    end_seen = 0;
  endtask
  // ==========================================================================
  // main sequence
  initial
  begin
    int ck_exp[6];
    ck_exp = '{0, 60 / pmsmr_pkg::NIBBLE_PERIOD, 30, 30, 30, 0};
    {sys_rst, link_up} = 2'h3;
    {rx_active, rx_valid, reg_we, tx_valid, tx_last} = '0;
    {rx_data, tx_data, reg_addr, reg_wdata} = '0;
    restart(1'b0, 1'b0, 1'b0, 3'h1, 1'b0);
    reg_rd(pmsmr_pkg::ADDR_CTRL_ONE, pmsmr_pkg::CTRL_RESET);
    reg_rd(pmsmr_pkg::ADDR_CTRL_TWO, pmsmr_pkg::CTRL_RESET);
    for (int c = 0; c < 6; c++)
    begin
      reg_wr(pmsmr_pkg::ADDR_CTRL_ONE, {9'h0, c[2:0], 4'h0});
      count_rises(0, ck_exp[c]);
    end
    link_up = 1'b0;
    reg_wr(pmsmr_pkg::ADDR_CTRL_ONE, 16'h0040);
    count_rises(0, 0);
    reg_wr(pmsmr_pkg::ADDR_CTRL_TWO, 16'h0010);
    count_rises(1, ck_exp[1]);
    reg_wr(pmsmr_pkg::ADDR_CTRL_ONE, 16'h1000);
    count_rises(2, ck_exp[1]);
    reg_rd(pmsmr_pkg::ADDR_CTRL_ONE, 16'h1000);
    reg_wr(16'h0464, 16'hFFFF);
    reg_rd(16'h0464, 16'h0000);
    reg_rd(pmsmr_pkg::ADDR_CTRL_TWO, 16'h0010);
    link_up = 1'b1;
    traffic(8);
    chk(crs_seen, 1'b1);
    chk(col_seen, 1'b0);
    restart(1'b0, 1'b0, 1'b1, 3'h4, 1'b0);
    traffic(8);
    chk(col_seen, 1'b1);
    restart(1'b1, 1'b0, 1'b0, 3'h4, 1'b1);
    repeat (4) @(negedge ref_clk);
    chk(strap_is_master, 1'b1);
    count_rises(2, 60 / pmsmr_pkg::REDUCED_PERIOD);
    traffic(8);
    restart(1'b0, 1'b1, 1'b0, 3'h2, 1'b0);
    traffic(4);
    restart(1'b1, 1'b1, 1'b0, 3'h3, 1'b0);
    traffic(4);
    restart(1'b1, 1'b0, 1'b0, 3'h1, 1'b0);
    rx_active = 1'b1;
    line_push(4'h5);
    @(negedge ref_clk);
    rx_valid = 1'b0;
    repeat (60) @(negedge ref_clk);
    rx_active = 1'b0;
    repeat (40) @(negedge ref_clk);
    chk(err_seen, 1'b1);
    stop_test();
  end
endmodule // tb_phy_mac_side_mii_rmii
